// ---- logic/sdc_pkg.sv ----
/*
 sdc_pkg: sizes, command codes, timing counts and types of the
 command and bank block. assumes a 50 MHz sys_clk.
*/
`default_nettype none
package sdc_pkg;
	localparam int BANKS = 8;
	localparam int BA_W = 3;
	localparam int ROW_W = 14;
	localparam int COL_W = 3;
	localparam int DQ_W = 16;
	localparam int MASK_W = 2;
	localparam int CAL_W = 6;
	localparam int CNT_W = 8;
	localparam int MEM_AW = BA_W + 2 + COL_W;
	localparam int FIFO_W = MEM_AW + MASK_W + DQ_W;
	localparam int FIFO_DEPTH = 8;
	// timing in ns, converted to sys_clk cycles; short calibration given in link cycles
	localparam int CLK_PERIOD_PS = 20000;
	localparam int ROW_CLOSE_NS = 15;
	localparam int REFRESH_CYCLE_NS = 160;
	localparam int INIT_CAL_NS = 640;
	localparam int RUN_CAL_NS = 320;
	localparam int SHORT_CAL_LINK_CYC = 64;
	localparam int ROW_CLOSE_CYC =
		(ROW_CLOSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REFRESH_CYC =
		(REFRESH_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INIT_CAL_CYC = INIT_CAL_NS * 1000 / CLK_PERIOD_PS;
	localparam int RUN_CAL_CYC = RUN_CAL_NS * 1000 / CLK_PERIOD_PS;
	// {ras_n, cas_n, we_n} with chip select low
	localparam logic [2:0] CMD_MODE = 3'h0;
	localparam logic [2:0] CMD_REFRESH = 3'h1;
	localparam logic [2:0] CMD_PRECHARGE = 3'h2;
	localparam logic [2:0] CMD_ACTIVATE = 3'h3;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_CAL = 3'h6;
	localparam logic [2:0] CMD_IDLE = 3'h7;
	localparam logic [3:0] LEN_FULL = 4'h8;
	localparam logic [3:0] LEN_CHOP = 4'h4;
	localparam int AUTOCLOSE_BIT = 10;
	localparam int CHOP_BIT = 12;
	localparam logic [CAL_W-1:0] DRV_RESET = 6'h20;
	localparam logic [CAL_W-1:0] TERM_RESET = 6'h20;
	typedef enum logic [1:0] {
		BANK_IDLE = 2'b00,
		BANK_OPEN = 2'b01,
		BANK_CLOSING = 2'b10
	} sdc_bank_type;
	typedef enum logic [1:0] {
		BURST_NONE = 2'b00,
		BURST_READ = 2'b01,
		BURST_WRITE = 2'b10
	} sdc_burst_type;
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_LONG = 2'b01,
		CAL_SHORT = 2'b10
	} sdc_cal_type;
	// every pin that crosses into sys_clk, synchronised as one word
	typedef struct packed {
		logic otf_enable;
		logic chop_fixed;
		logic [CAL_W-1:0] drv_ref;
		logic [CAL_W-1:0] term_ref;
		logic [MASK_W-1:0] byte_mask;
		logic [DQ_W-1:0] dq;
		logic [ROW_W-1:0] addr;
		logic [BA_W-1:0] ba;
		logic we_n;
		logic cas_n;
		logic ras_n;
		logic cs_n;
		logic cke;
		logic link_clk;
	} sdc_pins_type;
endpackage : sdc_pkg
`default_nettype wire

// ---- logic/sdc_fifo.sv ----
/*
 sdc_fifo: synchronous valid/ready fifo, width and depth as parameters.
 assumes one clock, depth a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slots;
		logic [PW-1:0] wr_ptr;
		logic [PW-1:0] rd_ptr;
		logic [PW:0] fill;
	} sdc_fifo_state_type;
	sdc_fifo_state_type r, n;
	logic push, pop;

	// full and empty come straight from the fill count
	assign in_ready = r.fill != (PW + 1)'(DEPTH);
	assign out_valid = r.fill != '0;
	assign out_data = r.slots[r.rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb begin
		n = r;
		if (push) begin
			n.slots[r.wr_ptr] = in_data;
			n.wr_ptr = r.wr_ptr + 1'b1;
		end
		if (pop) begin
			n.rd_ptr = r.rd_ptr + 1'b1;
		end
		n.fill = r.fill + (PW + 1)'(push) - (PW + 1)'(pop);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end
endmodule : sdc_fifo
`default_nettype wire

// ---- logic/sdc_mem.sv ----
/*
 sdc_mem: small byte-enabled array standing in for the cell array.
 assumes one clock; read data registered, valid one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_mem #(
	parameter int AW = 8,
	parameter int BYTES = 2
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [BYTES*8-1:0] wr_data,
	input wire logic [BYTES-1:0] wr_byte_en,
	input wire logic rd_en,
	input wire logic [AW-1:0] rd_addr,
	output logic [BYTES*8-1:0] rd_data,
	output logic rd_valid
);
	logic [BYTES*8-1:0] cells [2**AW];

	// one lane per byte; a disabled lane keeps its old content
	always_ff @(posedge clk) begin
		for (int g = 0; g < BYTES; g++) begin
			if (wr_en && wr_byte_en[g]) begin
				cells[wr_addr][g*8 +: 8] <= wr_data[g*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data <= '0;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= cells[rd_addr];
			end
		end
	end
endmodule : sdc_mem
`default_nettype wire

// ---- logic/sdc_command_bank.sv ----
/*
 sdc_command_bank: command decode, bank state, bursts, calibration
 and refresh of the memory device. assumes all pins come from another
 domain; link_clk_pin is sampled and its rising edges found here.
*/
// Behaviour
// [RULE_01] chip select high or idle command: nothing new, running work continues
// [RULE_02] long calibration runs engine, then loads driver and termination values
// [RULE_03] controller waits init or run window before using long calibration
// [RULE_04] short calibration steps impedance within 64 link cycles
// [RULE_05] activate opens addressed row in selected bank until precharged
// [RULE_06] controller precharges a bank before opening another row there
// [RULE_07] read starts burst at column from low address, samples autoclose bit
// [RULE_08] autoclose closes the row after the burst, else row stays open
// [RULE_09] with on-the-fly enabled, chop bit low gives four, high gives eight
// [RULE_10] a started read burst always runs to its end
// [RULE_11] read and write codes differ in write enable; variants in two bits
// [RULE_12] write starts burst in selected bank, autoclose and chop as read
// [RULE_13] masked bytes are skipped, unmasked bytes written to the array
// [RULE_14] precharge closes one bank, or all when autoclose bit high
// [RULE_15] controller waits row close time before reusing a precharged bank
// [RULE_16] access to another bank allowed during auto precharge
// [RULE_17] controller activates an idle bank before reading or writing it
// [RULE_18] precharge of idle bank does nothing; closing bank restarts period
// [RULE_19] refresh uses internal row counter, ignores address, one per command
// [RULE_20] controller keeps average refresh interval within temperature limit
// [RULE_21] controller postpones at most eight refreshes, sixteen per two intervals
// [RULE_22] controller sends only idle commands during refresh cycle time
// [RULE_23] controller holds clock enable high for precharge, activate, refresh
// [RULE_24] commands decoded from select, strobes and clock enable at rising edge
// [RULE_25] neither read nor write bursts are cut short
// [RULE_26] each bank tracks idle or open and which row is open
`timescale 1ns/1ps
`default_nettype none
module sdc_command_bank #(
	parameter int FIFO_DEPTH = sdc_pkg::FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic link_clk_pin,
	input wire logic cke_pin,
	input wire logic cs_n_pin,
	input wire logic ras_n_pin,
	input wire logic cas_n_pin,
	input wire logic we_n_pin,
	input wire logic [sdc_pkg::BA_W-1:0] bank_addr_pin,
	input wire logic [sdc_pkg::ROW_W-1:0] addr_pin,
	input wire logic [sdc_pkg::DQ_W-1:0] dq_in,
	output logic [sdc_pkg::DQ_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic [sdc_pkg::MASK_W-1:0] byte_mask_pin,
	input wire logic otf_enable,
	input wire logic chop_fixed,
	input wire logic [sdc_pkg::CAL_W-1:0] drv_ref_code,
	input wire logic [sdc_pkg::CAL_W-1:0] term_ref_code,
	output logic [sdc_pkg::CAL_W-1:0] driver_strength_value,
	output logic [sdc_pkg::CAL_W-1:0] termination_value,
	output logic cal_busy,
	output logic init_cal_done,
	output logic refresh_busy,
	output logic [sdc_pkg::ROW_W-1:0] refresh_row,
	output logic [15:0] refresh_total,
	output logic [sdc_pkg::BANKS-1:0] bank_open_map,
	output logic write_buffer_ready,
	output logic cmd_ignored
);
	typedef struct packed {
		sdc_pkg::sdc_pins_type sync1;
		sdc_pkg::sdc_pins_type sync2;
		logic clk_prev;
		sdc_pkg::sdc_bank_type [sdc_pkg::BANKS-1:0] bank;
		logic [sdc_pkg::BANKS-1:0][sdc_pkg::ROW_W-1:0] open_row;
		logic [sdc_pkg::BANKS-1:0][sdc_pkg::CNT_W-1:0] close_cnt;
		sdc_pkg::sdc_burst_type burst;
		logic [sdc_pkg::BA_W-1:0] burst_bank;
		logic [sdc_pkg::COL_W-1:0] burst_col;
		logic [3:0] burst_left;
		logic burst_chop;
		logic burst_close;
		logic [sdc_pkg::DQ_W-1:0] dq_out;
		logic dq_oe;
		sdc_pkg::sdc_cal_type cal;
		logic [sdc_pkg::CNT_W-1:0] cal_cnt;
		logic init_done;
		logic [sdc_pkg::CAL_W-1:0] drv;
		logic [sdc_pkg::CAL_W-1:0] term;
		logic [sdc_pkg::CNT_W-1:0] ref_cnt;
		logic [sdc_pkg::ROW_W-1:0] ref_row;
		logic [15:0] ref_total;
		logic ignored;
	} sdc_state_type;

	sdc_state_type r, n;
	sdc_pkg::sdc_pins_type pins_now, p;
	logic link_edge, take;
	logic [2:0] cmd;
	logic [sdc_pkg::MEM_AW-1:0] beat_addr;
	logic mem_rd_en, mem_rd_valid;
	logic [sdc_pkg::DQ_W-1:0] mem_rd_data;
	logic fifo_in_valid, fifo_in_ready;
	logic [sdc_pkg::FIFO_W-1:0] fifo_in_data, fifo_out_data;
	logic fifo_out_valid, fifo_out_ready;
	logic [sdc_pkg::MEM_AW-1:0] drain_addr;
	logic [sdc_pkg::MASK_W-1:0] drain_mask;
	logic [sdc_pkg::DQ_W-1:0] drain_data;

	// moves a code one step toward its reference per short calibration
	function automatic logic [sdc_pkg::CAL_W-1:0] cal_step(
		input logic [sdc_pkg::CAL_W-1:0] cur,
		input logic [sdc_pkg::CAL_W-1:0] target
	);
		logic [sdc_pkg::CAL_W-1:0] res;
		res = cur;
		if (cur < target) begin
			res = cur + 1'b1;
		end else if (cur > target) begin
			res = cur - 1'b1;
		end
		return res;
	endfunction : cal_step

	// next column in burst order: chop wraps in four, full in eight
	function automatic logic [sdc_pkg::COL_W-1:0] col_next(
		input logic [sdc_pkg::COL_W-1:0] col,
		input logic chop
	);
		logic [sdc_pkg::COL_W-1:0] res;
		res = col + 1'b1;
		if (chop) begin
			res = {col[2], col[1:0] + 2'h1};
		end
		return res;
	endfunction : col_next

	assign pins_now = '{otf_enable: otf_enable, chop_fixed: chop_fixed,
		drv_ref: drv_ref_code, term_ref: term_ref_code,
		byte_mask: byte_mask_pin, dq: dq_in, addr: addr_pin,
		ba: bank_addr_pin, we_n: we_n_pin, cas_n: cas_n_pin,
		ras_n: ras_n_pin, cs_n: cs_n_pin, cke: cke_pin,
		link_clk: link_clk_pin};

	// only the second stage is read; all pins share the same delay
	assign p = r.sync2;
	assign link_edge = p.link_clk & ~r.clk_prev;
	assign cmd = {p.ras_n, p.cas_n, p.we_n};
	assign take = link_edge & p.cke & ~p.cs_n; // RULE_24

	assign beat_addr = {r.burst_bank, r.open_row[r.burst_bank][1:0], r.burst_col};
	assign mem_rd_en = link_edge && r.burst == sdc_pkg::BURST_READ;
	assign fifo_in_valid = link_edge && r.burst == sdc_pkg::BURST_WRITE;
	assign fifo_in_data = {beat_addr, p.byte_mask, p.dq}; // RULE_13
	// a read beat owns the array port, so the drain stalls behind it
	assign fifo_out_ready = ~mem_rd_en;
	assign {drain_addr, drain_mask, drain_data} = fifo_out_data;

	always_comb begin
		n = r;
		n.sync1 = pins_now;
		n.sync2 = r.sync1;
		n.clk_prev = r.sync2.link_clk;
		n.ignored = 1'b0;

		// closing banks count down to idle
		for (int b = 0; b < sdc_pkg::BANKS; b++) begin
			if (r.bank[b] == sdc_pkg::BANK_CLOSING) begin
				if (r.close_cnt[b] <= sdc_pkg::CNT_W'(1)) begin
					n.bank[b] = sdc_pkg::BANK_IDLE;
					n.close_cnt[b] = '0;
				end else begin
					n.close_cnt[b] = r.close_cnt[b] - 1'b1;
				end
			end
		end

		// burst beats, one per link edge; nothing stops them early
		if (link_edge && r.burst != sdc_pkg::BURST_NONE) begin // RULE_10 RULE_25
			n.burst_col = col_next(r.burst_col, r.burst_chop); // RULE_07
			n.burst_left = r.burst_left - 4'h1;
			if (r.burst_left == 4'h1) begin
				n.burst = sdc_pkg::BURST_NONE;
				if (r.burst_close) begin // RULE_08
					n.bank[r.burst_bank] = sdc_pkg::BANK_CLOSING;
					n.close_cnt[r.burst_bank] =
						sdc_pkg::CNT_W'(sdc_pkg::ROW_CLOSE_CYC);
				end
			end
		end

		// read data goes out a cycle after the array read
		if (mem_rd_valid) begin
			n.dq_out = mem_rd_data;
			n.dq_oe = 1'b1;
		end else if (link_edge && r.burst != sdc_pkg::BURST_READ) begin
			n.dq_oe = 1'b0;
		end

		// calibration engine
		if (r.cal != sdc_pkg::CAL_IDLE) begin
			if (r.cal_cnt == '0) begin
				if (r.cal == sdc_pkg::CAL_LONG) begin
					n.drv = p.drv_ref; // RULE_02
					n.term = p.term_ref;
					n.init_done = 1'b1;
				end else begin
					n.drv = cal_step(r.drv, p.drv_ref); // RULE_04
					n.term = cal_step(r.term, p.term_ref);
				end
				n.cal = sdc_pkg::CAL_IDLE;
			end else if (r.cal == sdc_pkg::CAL_LONG || link_edge) begin
				n.cal_cnt = r.cal_cnt - 1'b1;
			end
		end

		// refresh busy window
		if (r.ref_cnt != '0) begin
			n.ref_cnt = r.ref_cnt - 1'b1;
		end

		// deselect and idle fall out here: take low or default branch
		if (take) begin // RULE_01
			case (cmd)
				sdc_pkg::CMD_ACTIVATE: begin
					if (r.bank[p.ba] == sdc_pkg::BANK_IDLE) begin // RULE_26
						n.bank[p.ba] = sdc_pkg::BANK_OPEN; // RULE_05
						n.open_row[p.ba] = p.addr;
					end else begin
						n.ignored = 1'b1;
					end
				end
				sdc_pkg::CMD_READ, sdc_pkg::CMD_WRITE: begin // RULE_11
					// a bank closing on its own does not block this one
					if (r.bank[p.ba] == sdc_pkg::BANK_OPEN // RULE_16
						&& r.burst == sdc_pkg::BURST_NONE) begin
						n.burst = (cmd == sdc_pkg::CMD_READ) ?
							sdc_pkg::BURST_READ : sdc_pkg::BURST_WRITE; // RULE_12
						n.burst_bank = p.ba;
						n.burst_col = p.addr[sdc_pkg::COL_W-1:0]; // RULE_07
						n.burst_close = p.addr[sdc_pkg::AUTOCLOSE_BIT];
						n.burst_chop = p.otf_enable ? // RULE_09
							~p.addr[sdc_pkg::CHOP_BIT] : p.chop_fixed;
						n.burst_left = n.burst_chop ?
							sdc_pkg::LEN_CHOP : sdc_pkg::LEN_FULL;
					end else begin
						n.ignored = 1'b1;
					end
				end
				sdc_pkg::CMD_PRECHARGE: begin
					for (int b = 0; b < sdc_pkg::BANKS; b++) begin
						if (p.addr[sdc_pkg::AUTOCLOSE_BIT] // RULE_14
							|| p.ba == sdc_pkg::BA_W'(b)) begin
							// an idle bank treats it as idle; closing restarts
							if (r.bank[b] != sdc_pkg::BANK_IDLE) begin // RULE_18
								n.bank[b] = sdc_pkg::BANK_CLOSING;
								n.close_cnt[b] =
									sdc_pkg::CNT_W'(sdc_pkg::ROW_CLOSE_CYC);
							end
						end
					end
				end
				sdc_pkg::CMD_REFRESH: begin
					n.ref_cnt = sdc_pkg::CNT_W'(sdc_pkg::REFRESH_CYC); // RULE_19
					n.ref_row = r.ref_row + 1'b1;
					n.ref_total = r.ref_total + 16'h1;
				end
				sdc_pkg::CMD_CAL: begin
					if (r.cal != sdc_pkg::CAL_IDLE) begin
						n.ignored = 1'b1;
					end else if (p.addr[sdc_pkg::AUTOCLOSE_BIT]) begin
						n.cal = sdc_pkg::CAL_LONG; // RULE_02
						n.cal_cnt = r.init_done ?
							sdc_pkg::CNT_W'(sdc_pkg::RUN_CAL_CYC) :
							sdc_pkg::CNT_W'(sdc_pkg::INIT_CAL_CYC);
					end else begin
						n.cal = sdc_pkg::CAL_SHORT; // RULE_04
						n.cal_cnt = sdc_pkg::CNT_W'(sdc_pkg::SHORT_CAL_LINK_CYC);
					end
				end
				default: begin
					// idle and mode commands register nothing here
					n.ignored = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			r <= '0;
			r.drv <= sdc_pkg::DRV_RESET;
			r.term <= sdc_pkg::TERM_RESET;
		end else begin
			r <= n;
		end
	end

	// write beats wait here until the array port is free
	sdc_fifo #(
		.WIDTH(sdc_pkg::FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_wfifo (
		.clk(sys_clk),
		.reset(reset),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	sdc_mem #(
		.AW(sdc_pkg::MEM_AW),
		.BYTES(sdc_pkg::MASK_W)
	) u_array (
		.clk(sys_clk),
		.reset(reset),
		.wr_en(fifo_out_valid & fifo_out_ready),
		.wr_addr(drain_addr),
		.wr_data(drain_data),
		.wr_byte_en(~drain_mask), // RULE_13
		.rd_en(mem_rd_en),
		.rd_addr(beat_addr),
		.rd_data(mem_rd_data),
		.rd_valid(mem_rd_valid)
	);

	// outputs
	assign dq_out = r.dq_out;
	assign dq_oe = r.dq_oe;
	assign driver_strength_value = r.drv;
	assign termination_value = r.term;
	assign cal_busy = r.cal != sdc_pkg::CAL_IDLE;
	assign init_cal_done = r.init_done;
	assign refresh_busy = r.ref_cnt != '0;
	assign refresh_row = r.ref_row;
	assign refresh_total = r.ref_total;
	assign write_buffer_ready = fifo_in_ready;
	assign cmd_ignored = r.ignored;
	for (genvar g = 0; g < sdc_pkg::BANKS; g++) begin : g_map
		assign bank_open_map[g] = r.bank[g] == sdc_pkg::BANK_OPEN;
	end
endmodule : sdc_command_bank
`default_nettype wire

// ---- dv/sdc_command_bank_props.sv ----
/*
 sdc_command_bank_props: assertions on the command block's ports.
 assumes the bind below; pins settle between link edges.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_command_bank_props (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic link_clk_pin,
	input wire logic cke_pin,
	input wire logic cs_n_pin,
	input wire logic ras_n_pin,
	input wire logic cas_n_pin,
	input wire logic we_n_pin,
	input wire logic [sdc_pkg::BA_W-1:0] bank_addr_pin,
	input wire logic [sdc_pkg::ROW_W-1:0] addr_pin,
	input wire logic dq_oe,
	input wire logic [sdc_pkg::CAL_W-1:0] driver_strength_value,
	input wire logic [sdc_pkg::CAL_W-1:0] termination_value,
	input wire logic cal_busy,
	input wire logic refresh_busy,
	input wire logic [sdc_pkg::ROW_W-1:0] refresh_row,
	input wire logic [15:0] refresh_total,
	input wire logic [sdc_pkg::BANKS-1:0] bank_open_map,
	input wire logic cmd_ignored
);
	logic [22:0] s1_r, s2_r;
	logic prev_r, take, valid;
	logic [2:0] code, c_ba;
	// same two-flop resync and edge detect as the block
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s1_r <= '0;
			s2_r <= '0;
			prev_r <= 1'b0;
		end else begin
			s1_r <= {link_clk_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin,
				bank_addr_pin, addr_pin};
			s2_r <= s1_r;
			prev_r <= s2_r[22];
		end
	end
	assign take = s2_r[22] && !prev_r;
	assign valid = take && s2_r[21] && !s2_r[20];
	assign code = s2_r[19:17];
	assign c_ba = s2_r[16:14];
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	sequence s_ref_start;
		refresh_busy && refresh_row == $past(refresh_row) + 14'h0001
			&& refresh_total == $past(refresh_total) + 16'h0001;
	endsequence
	sequence s_out_run;
		dq_oe [*8];
	endsequence
	quiet_cmd_a: assert property (
		take && (!s2_r[21] || s2_r[20] || code == sdc_pkg::CMD_IDLE)
		|=> (bank_open_map & ~$past(bank_open_map)) == '0 && !cmd_ignored && !$rose(refresh_busy))
		else $error("idle cycle changed state");
	act_opens_a: assert property (
		valid && code == sdc_pkg::CMD_ACTIVATE && !bank_open_map[c_ba]
		|=> bank_open_map[$past(c_ba)] || cmd_ignored)
		else $error("activate left its bank closed");
	act_refused_a: assert property (
		valid && code == sdc_pkg::CMD_ACTIVATE && bank_open_map[c_ba]
		|=> cmd_ignored && bank_open_map[$past(c_ba)])
		else $error("activate to open bank not refused");
	access_idle_a: assert property (
		valid && (code == sdc_pkg::CMD_READ || code == sdc_pkg::CMD_WRITE) && !bank_open_map[c_ba]
		|=> cmd_ignored)
		else $error("access to closed bank not refused");
	pre_all_a: assert property (
		valid && code == sdc_pkg::CMD_PRECHARGE && s2_r[10] |=> bank_open_map == '0)
		else $error("precharge all left a bank open");
	pre_one_a: assert property (
		valid && code == sdc_pkg::CMD_PRECHARGE && !s2_r[10]
		|=> !bank_open_map[$past(c_ba)] && (bank_open_map & ~$past(bank_open_map)) == '0)
		else $error("one-bank precharge wrong");
	refresh_step_a: assert property (
		valid && code == sdc_pkg::CMD_REFRESH |=> s_ref_start ##1 refresh_busy [*7])
		else $error("refresh counters or busy wrong");
	cal_codes_a: assert property (
		!cal_busy && !$past(cal_busy) |-> $stable(driver_strength_value) && $stable(termination_value))
		else $error("codes moved outside calibration");
	read_run_a: assert property (
		$rose(dq_oe) |-> s_out_run)
		else $error("read output dropped early");
endmodule : sdc_command_bank_props
bind sdc_command_bank sdc_command_bank_props i_sdc_command_bank_props (.*);
`default_nettype wire

// ---- dv/sdc_ctrl_model.sv ----
/*
 sdc_ctrl_model: controller model on the command, address and data pins.
 assumes the bench calls issue and beats; run starts the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sdc_ctrl_model (
	input wire logic run,
	input wire logic [15:0] dq_out,
	input wire logic dq_oe,
	output logic link_clk_pin,
	output logic cke_pin,
	output logic cs_n_pin,
	output logic ras_n_pin,
	output logic cas_n_pin,
	output logic we_n_pin,
	output logic [2:0] bank_addr_pin,
	output logic [13:0] addr_pin,
	output wire logic [15:0] dq_in,
	output logic [1:0] byte_mask_pin
);
	logic [15:0] dq_drv;
	// device's word while it drives, ours otherwise
	assign dq_in = dq_oe ? dq_out : dq_drv;
	// free-running 160 ns clock, offset off the sys_clk edges
	initial begin
		link_clk_pin = 1'b0;
		{cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 5'h1F;
		{bank_addr_pin, addr_pin} = 17'h00000;
		dq_drv = 16'h0000;
		byte_mask_pin = 2'h3;
		#3;
		forever begin
			#80;
			if (run) link_clk_pin = ~link_clk_pin;
		end
	end
	// command held from one fall to the next, taken at the rise
	task automatic issue(input logic cke, input logic cs_n, input logic [2:0] cmd,
		input logic [2:0] ba, input logic [13:0] addr);
		@(negedge link_clk_pin);
		{cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = {cke, cs_n, cmd};
		{bank_addr_pin, addr_pin} = {ba, addr};
		@(posedge link_clk_pin);
		@(negedge link_clk_pin);
		// then deselect; address shows the inverse, not the old value
		{cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin} = 5'h1F;
		{bank_addr_pin, addr_pin} = ~{ba, addr};
	endtask : issue
	// write beats, one per rise after the command
	task automatic beats(input int n, input logic [15:0] base, input logic [1:0] mask);
		for (int i = 0; i < n; i++) begin
			dq_drv = base + 16'(i);
			byte_mask_pin = mask;
			@(posedge link_clk_pin);
			@(negedge link_clk_pin);
		end
		dq_drv = ~dq_drv;
		byte_mask_pin = ~mask;
	endtask : beats
endmodule : sdc_ctrl_model
`default_nettype wire

// ---- dv/test_sdc_command_bank.sv ----
/*
 test_sdc_command_bank: scenario bench for the command and bank block.
 assumes sdc_ctrl_model on the pins and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sdc_command_bank;
	localparam logic [2:0] ACT = sdc_pkg::CMD_ACTIVATE;
	localparam logic [2:0] RD = sdc_pkg::CMD_READ;
	localparam logic [2:0] WR = sdc_pkg::CMD_WRITE;
	localparam logic [2:0] PRE = sdc_pkg::CMD_PRECHARGE;
	logic sys_clk, reset, run, otf_enable, chop_fixed, ign_seen;
	logic [5:0] drv_ref_code, term_ref_code;
	wire logic link_clk_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, dq_oe;
	wire logic cal_busy, init_cal_done, refresh_busy, write_buffer_ready, cmd_ignored;
	wire logic [2:0] bank_addr_pin;
	wire logic [13:0] addr_pin, refresh_row;
	wire logic [15:0] dq_in, dq_out, refresh_total;
	wire logic [1:0] byte_mask_pin;
	wire logic [5:0] driver_strength_value, termination_value;
	wire logic [7:0] bank_open_map;
	int err_count, n_tests;
	logic [15:0] exp_mem [256];
	sdc_command_bank i_sdc_command_bank (.*);
	sdc_ctrl_model i_sdc_ctrl_model (.*);
	always #10 sys_clk = ~sys_clk;
	// latch the one-cycle refusal pulse mid-cycle
	always @(negedge sys_clk) begin
		if (cmd_ignored === 1'b1) ign_seen = 1'b1;
	end
	task automatic check(input string w, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", w, e, g);
		end
	endtask : check
	task automatic end_sim;
		$display("mismatches %0d, comparisons %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic cmd(input logic [2:0] c, input logic [2:0] ba, input logic [13:0] a);
		i_sdc_ctrl_model.issue(1'b1, 1'b0, c, ba, a);
	endtask : cmd
	// column of beat i; chop wraps in its group of four
	function automatic logic [2:0] col_at(input logic [2:0] s, input int i, input logic chop);
		logic [2:0] c;
		c = s + 3'(i);
		return chop ? {s[2], c[1:0]} : c;
	endfunction : col_at
	task automatic t_reset;
		check("dq_oe", 16'h0000, 16'(dq_oe));
		check("drive code", 16'h0020, 16'(driver_strength_value));
		check("term code", 16'h0020, 16'(termination_value));
		check("open map", 16'h0000, 16'(bank_open_map));
		check("flags", 16'h0000, 16'({cal_busy, refresh_busy, init_cal_done}));
		check("buffer ready", 16'h0001, 16'(write_buffer_ready));
	endtask : t_reset
	task automatic t_deselect;
		ign_seen = 1'b0;
		i_sdc_ctrl_model.issue(1'b1, 1'b1, ACT, 3'h4, 14'h0011);
		cmd(sdc_pkg::CMD_IDLE, 3'h4, 14'h0011);
		i_sdc_ctrl_model.issue(1'b0, 1'b0, ACT, 3'h4, 14'h0011);
		check("open map", 16'h0000, 16'(bank_open_map));
		check("refused", 16'h0000, 16'(ign_seen));
	endtask : t_deselect
	task automatic t_refused;
		ign_seen = 1'b0;
		cmd(RD, 3'h5, 14'h0000);
		check("refused", 16'h0001, 16'(ign_seen));
		ign_seen = 1'b0;
		cmd(ACT, 3'h5, 14'h0022);
		check("dq_oe", 16'h0000, 16'(dq_oe));
		cmd(ACT, 3'h5, 14'h0023);
		check("refused", 16'h0001, 16'(ign_seen));
		check("open map", 16'h0020, 16'(bank_open_map));
	endtask : t_refused
	task automatic t_precharge;
		cmd(ACT, 3'h1, 14'h0001);
		check("open map", 16'h0022, 16'(bank_open_map));
		cmd(PRE, 3'h5, 14'h0000);
		check("open map", 16'h0002, 16'(bank_open_map));
		cmd(PRE, 3'h5, 14'h0000);
		check("open map", 16'h0002, 16'(bank_open_map));
		cmd(PRE, 3'h6, 14'h0400);
		check("open map", 16'h0000, 16'(bank_open_map));
	endtask : t_precharge
	task automatic t_refresh;
		for (int k = 1; k <= 2; k++) begin
			cmd(sdc_pkg::CMD_REFRESH, 3'(k), 14'(k * 7));
			check("refresh row", 16'(k), 16'(refresh_row));
			check("refresh count", 16'(k), refresh_total);
			check("refresh busy", 16'h0001, 16'(refresh_busy));
		end
	endtask : t_refresh
	task automatic wait_cal;
		int k = 0;
		while (cal_busy !== 1'b0 && k < 2000) begin
			@(negedge sys_clk);
			k++;
		end
		if (k == 2000) begin
			err_count++;
			$display("unexpected cal_busy: expected 0, seen 1");
			end_sim();
		end
		repeat (2) @(negedge sys_clk);
	endtask : wait_cal
	task automatic t_cal;
		drv_ref_code = 6'h2A;
		term_ref_code = 6'h11;
		cmd(sdc_pkg::CMD_CAL, 3'h0, 14'h0400);
		check("cal busy", 16'h0001, 16'(cal_busy));
		wait_cal();
		check("drive code", 16'h002A, 16'(driver_strength_value));
		check("term code", 16'h0011, 16'(termination_value));
		check("init done", 16'h0001, 16'(init_cal_done));
		drv_ref_code = 6'h30;
		term_ref_code = 6'h05;
		cmd(sdc_pkg::CMD_CAL, 3'h0, 14'h0000);
		wait_cal();
		check("drive code", 16'h002B, 16'(driver_strength_value));
		check("term code", 16'h0010, 16'(termination_value));
	endtask : t_cal
	task automatic rd_check(input logic [13:0] a, input int n);
		cmd(RD, 3'h3, a);
		@(posedge link_clk_pin);
		for (int i = 0; i < n; i++) begin
			@(posedge link_clk_pin);
			check("read word", exp_mem[{5'h0D, col_at(a[2:0], i, n == 4)}], dq_out);
			check("read enable", 16'h0001, 16'(dq_oe));
		end
	endtask : rd_check
	// full and masked chop writes, then full and auto-close chop reads
	task automatic t_burst;
		otf_enable = 1'b1;
		cmd(ACT, 3'h3, 14'h0005);
		cmd(WR, 3'h3, 14'h1005);
		i_sdc_ctrl_model.beats(8, 16'hA100, 2'h0);
		for (int i = 0; i < 8; i++) exp_mem[{5'h0D, col_at(3'h5, i, 1'b0)}] = 16'hA100 + 16'(i);
		cmd(WR, 3'h3, 14'h0006);
		i_sdc_ctrl_model.beats(4, 16'h5B00, 2'h1);
		for (int i = 0; i < 4; i++) exp_mem[{5'h0D, col_at(3'h6, i, 1'b1)}][15:8] = 8'h5B;
		rd_check(14'h1000, 8);
		otf_enable = 1'b0;
		chop_fixed = 1'b1;
		rd_check(14'h1402, 4);
		repeat (2) @(posedge link_clk_pin);
		check("open map", 16'h0000, 16'(bank_open_map));
		check("dq_oe", 16'h0000, 16'(dq_oe));
	endtask : t_burst
	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		run = 1'b0;
		otf_enable = 1'b0;
		chop_fixed = 1'b0;
		ign_seen = 1'b0;
		drv_ref_code = 6'h20;
		term_ref_code = 6'h20;
		err_count = 0;
		n_tests = 0;
		repeat (10) @(negedge sys_clk);
		reset = 1'b0;
		t_reset();
		repeat (4) @(negedge sys_clk);
		run = 1'b1;
		t_deselect();
		t_refused();
		t_precharge();
		t_refresh();
		t_cal();
		t_burst();
		end_sim();
	end
endmodule : test_sdc_command_bank
`default_nettype wire
